// File: design/epf_pkg.sv
// Package: shared types and constants for the Ethernet packet FIFO block
`default_nettype none
package epf_pkg;
    // Octets in a station address
    localparam int ADDR_OCTETS = 6;
    // Bits per octet on the line
    localparam int OCTET_BITS = 8;
    // Interrupt source bit positions
    localparam int IRQ_RX = 0;
    localparam int IRQ_TX = 1;
    localparam int IRQ_RXOF = 2;
    localparam int IRQ_RXER = 3;
    localparam int IRQ_W = 4;
    // Reset values
    localparam logic [47:0] ADDR_RST = 48'h0000_0000_0000;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

    // Byte with start and end of packet marks
    typedef struct packed {
        logic [7:0] data;
        logic sop;
        logic eop;
    } epf_byte_t;

    // Receive-frame outcome from the line side
    typedef struct packed {
        logic done;
        logic fcs_ok;
        logic overflow;
    } epf_rx_evt_t;
endpackage : epf_pkg
`default_nettype wire

// File: design/epf_ser.sv
// Serialiser: sends a byte stream least significant bit first
`default_nettype none
module epf_ser
    import epf_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic sys_rst, // Synchronous reset
    input wire logic load, // Load new octet
    input wire logic [7:0] octet, // Octet to send
    output logic busy, // Octet in flight
    output logic bit_out, // Line bit
    output logic bit_vld // Line bit valid
);
    // All state in one struct
    typedef struct packed {
        logic [7:0] sh;
        logic [3:0] cnt;
        logic o;
        logic v;
    } epf_ser_st_t;
    epf_ser_st_t s_q, s_d;

    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.v = 1'b0;
        if (s_q.cnt != 4'h0) begin
            s_d.o = s_q.sh[0];
            s_d.v = 1'b1;
            s_d.sh = {1'b0, s_q.sh[7:1]};
            s_d.cnt = s_q.cnt - 4'h1;
        end else if (load) begin
            s_d.sh = octet;
            s_d.cnt = 4'(OCTET_BITS);
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = (s_q.cnt != 4'h0);
    assign bit_out = s_q.o;
    assign bit_vld = s_q.v;
endmodule // epf_ser
`default_nettype wire

// File: design/epf_top.sv
// Host-side packet path: one-packet TX FIFO, RX packet count, address, IRQ
// Operation
// - Raw and masked interrupt status both readable
// - Store six-octet address, filter unless promiscuous
// - Address octets go out first to last
// - Each octet sent least significant bit first
// - Packet count rises on good FCS end
// - Count falls after whole packet read
// - Partly read packet still counted
// - One packet held; request bit starts send
// - Receive interrupt while packets are waiting
// - Overflow interrupt when frame exceeds space
`default_nettype none
module epf_top
    import epf_pkg::*;
#(
    parameter int TX_DEPTH = 2048, // Transmit FIFO bytes
    parameter int CNT_W = 6 // Packet count width
)(
    input wire logic ref_clk, // Clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic addr_wr, // Load station address
    input wire logic [47:0] addr_in, // Address, first octet in [47:40]
    input wire logic promisc, // Promiscuous receive
    input wire logic addr_send, // Send the address on the line
    input wire logic tx_wr, // Host writes a TX byte
    input wire epf_byte_t tx_byte, // TX byte with marks
    input wire logic tx_go, // Transmit request
    input wire logic [15:0] tx_len, // Declared packet length
    input wire logic rx_rd, // Host pops a byte from RX
    input wire epf_byte_t rx_head, // Byte at RX FIFO head
    input wire epf_rx_evt_t rx_evt, // Frame outcome from line
    input wire logic [47:0] rx_dst, // Destination of received frame
    input wire logic [IRQ_W-1:0] irq_en, // Interrupt enable mask
    input wire logic [IRQ_W-1:0] irq_clr, // Clear status bits
    output logic [47:0] addr_q_o, // Stored station address
    output logic rx_accept, // Frame passes filter
    output logic [CNT_W-1:0] rx_count, // Packets in RX FIFO
    output logic tx_empty, // TX FIFO free
    output logic tx_reject, // Oversized or zero-length packet refused
    output logic line_bit, // Serial line bit
    output logic line_vld, // Serial line bit valid
    output logic [IRQ_W-1:0] irq_raw, // Raw status
    output logic [IRQ_W-1:0] irq_mask, // Masked status
    output logic irq // Processor interrupt
);
    ////////////////////////////////////////////////////////////////////////
    // State
    typedef enum {TX_IDLE, TX_LOAD, TX_SEND, TX_ADDR} epf_tx_st_t;
    typedef struct packed {
        epf_tx_st_t st;
        logic [47:0] addr;
        logic [15:0] wptr;
        logic [15:0] rptr;
        logic [15:0] len;
        logic [2:0] oct;
        logic [CNT_W-1:0] cnt;
        logic [IRQ_W-1:0] stat;
        logic acc;
        logic rej;
        logic empty;
        logic [IRQ_W-1:0] msk;
        logic irq;
    } epf_st_t;
    epf_st_t s_q, s_d;

    // Transmit packet store
    logic [7:0] tx_mem [TX_DEPTH];
    logic ser_load; // Load serialiser
    logic [7:0] ser_oct; // Octet to serialiser
    logic ser_busy; // Serialiser busy
    logic pkt_done; // TX packet finished
    logic pop_last; // Last byte of packet popped
    logic [IRQ_W-1:0] set_v; // Status set events

    ////////////////////////////////////////////////////////////////////////
    // Memory write port
    always_ff @(posedge ref_clk) begin
        if (s_q.st == TX_LOAD && tx_wr && s_q.wptr < 16'(TX_DEPTH)) begin
            tx_mem[s_q.wptr[$clog2(TX_DEPTH)-1:0]] <= tx_byte.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serialiser feed
    always_comb begin
        ser_load = 1'b0;
        ser_oct = 8'h00;
        pkt_done = 1'b0;
        if (!ser_busy && s_q.st == TX_SEND) begin
            ser_load = 1'b1;
            ser_oct = tx_mem[s_q.rptr[$clog2(TX_DEPTH)-1:0]];
            pkt_done = (s_q.rptr + 16'h1 == s_q.len);
        end else if (!ser_busy && s_q.st == TX_ADDR) begin
            ser_load = 1'b1;
            ser_oct = s_q.addr[47 - 8*s_q.oct -: 8];
        end
    end

    // Events feeding status
    always_comb begin
        pop_last = rx_rd && rx_head.eop;
        set_v = '0;
        set_v[IRQ_RX] = (s_q.cnt != '0);
        set_v[IRQ_TX] = pkt_done;
        set_v[IRQ_RXOF] = rx_evt.done && rx_evt.overflow;
        set_v[IRQ_RXER] = rx_evt.done && !rx_evt.fcs_ok && !rx_evt.overflow;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.rej = 1'b0;
        if (addr_wr) begin
            s_d.addr = addr_in;
        end
        s_d.acc = promisc || (rx_dst == s_q.addr) || rx_dst[40];
        // count good frames, drop after read
        unique case ({rx_evt.done && rx_evt.fcs_ok && !rx_evt.overflow,
                      pop_last && s_q.cnt != '0})
            2'b10: s_d.cnt = s_q.cnt + CNT_W'(1);
            2'b01: s_d.cnt = s_q.cnt - CNT_W'(1);
            default: s_d.cnt = s_q.cnt;
        endcase
        unique case (s_q.st)
            TX_IDLE: begin
                if (addr_send) begin
                    s_d.st = TX_ADDR;
                    s_d.oct = 3'h0;
                end else if (tx_wr) begin
                    s_d.st = TX_LOAD;
                    s_d.wptr = 16'h0;
                end
            end
            TX_LOAD: begin
                if (tx_wr) begin
                    s_d.wptr = s_q.wptr + 16'h1;
                end
                if (tx_go) begin
                    if (tx_len > 16'(TX_DEPTH) || tx_len == 16'h0) begin
                        s_d.rej = 1'b1;
                        s_d.st = TX_IDLE;
                    end else begin
                        s_d.len = tx_len;
                        s_d.rptr = 16'h0;
                        s_d.st = TX_SEND;
                    end
                end
            end
            TX_SEND: begin
                if (ser_load) begin
                    s_d.rptr = s_q.rptr + 16'h1;
                    if (pkt_done) begin
                        s_d.st = TX_IDLE;
                    end
                end
            end
            TX_ADDR: begin
                if (ser_load) begin
                    s_d.oct = s_q.oct + 3'h1;
                    if (s_q.oct == 3'(ADDR_OCTETS - 1)) begin
                        s_d.st = TX_IDLE;
                    end
                end
            end
        endcase
        // empty only when idle and serialiser drained
        s_d.empty = (s_d.st == TX_IDLE) && !ser_busy && !ser_load;
        s_d.stat = (s_q.stat & ~irq_clr) | set_v;
        s_d.msk = s_d.stat & irq_en;
        s_d.irq = |(s_d.stat & irq_en);
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_q <= '{st: TX_IDLE, addr: ADDR_RST, stat: IRQ_RST, empty: 1'b1,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Line serialiser
    epf_ser u_ser (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .load(ser_load),
        .octet(ser_oct),
        .busy(ser_busy),
        .bit_out(line_bit),
        .bit_vld(line_vld)
    );

    // Outputs from registers
    assign addr_q_o = s_q.addr;
    assign rx_accept = s_q.acc;
    assign rx_count = s_q.cnt;
    assign tx_empty = s_q.empty;
    assign tx_reject = s_q.rej;
    assign irq_raw = s_q.stat;
    assign irq_mask = s_q.msk;
    assign irq = s_q.irq;
endmodule // epf_top
`default_nettype wire

// File: verif/epf_props.sv
// Checker on the packet path top-level ports
`default_nettype none
module epf_props
    import epf_pkg::*;
#(
    parameter int TX_DEPTH = 2048, // TX FIFO bytes
    parameter int CNT_W = 6 // Count width
)(
    input wire logic ref_clk, // Clock
    input wire logic sys_rst, // Sync reset
    input wire logic addr_wr, // Address load
    input wire logic [47:0] addr_in, // Address in
    input wire logic promisc, // Promiscuous
    input wire logic rx_rd, // RX pop
    input wire epf_byte_t rx_head, // Popped byte
    input wire epf_rx_evt_t rx_evt, // Frame outcome
    input wire logic [IRQ_W-1:0] irq_clr, // Clear bits
    input wire logic [47:0] addr_q_o, // Stored address
    input wire logic rx_accept, // Filter result
    input wire logic [CNT_W-1:0] rx_count, // Packet count
    input wire logic tx_reject, // Refusal pulse
    input wire logic line_vld, // Line bit valid
    input wire logic [IRQ_W-1:0] irq_raw, // Raw status
    input wire logic [IRQ_W-1:0] irq_mask, // Masked status
    input wire logic irq // Interrupt line
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    chk_irq_or: assert property (irq == |irq_mask)
        else $error("irq line differs from masked OR");
    chk_mask_sub: assert property ((irq_mask & ~irq_raw) == '0)
        else $error("masked bit without raw bit");
    chk_count_up: assert property (rx_evt.done && rx_evt.fcs_ok && !rx_evt.overflow
        && promisc && !(rx_rd && rx_head.eop) |=> rx_count == $past(rx_count) + 1'b1)
        else $error("count did not rise on good frame");
    chk_count_down: assert property (rx_rd && rx_head.eop && !rx_evt.done && rx_count != 0
        |=> rx_count == $past(rx_count) - 1'b1) else $error("count did not fall");
    chk_count_hold: assert property (!rx_evt.done && !(rx_rd && rx_head.eop)
        |=> $stable(rx_count)) else $error("count moved without cause");
    chk_rx_pend: assert property (rx_count != 0 |=> irq_raw[IRQ_RX])
        else $error("rx pending status not set");
    chk_raw_sticky: assert property (1'b1 |=>
        ($past(irq_raw) & ~$past(irq_clr) & ~irq_raw) == '0) else $error("status bit lost");
    chk_reject_quiet: assert property (tx_reject |=> (!tx_reject && !line_vld)
        ##1 !line_vld [*3]) else $error("refused packet sent or long pulse");
    chk_addr_load: assert property (addr_wr |=> addr_q_o == $past(addr_in))
        else $error("address not stored");
    chk_promisc_acc: assert property (promisc |=> rx_accept)
        else $error("promiscuous frame refused");
endmodule // epf_props
bind epf_top epf_props #(.TX_DEPTH(TX_DEPTH), .CNT_W(CNT_W)) i_props (.ref_clk, .sys_rst,
    .addr_wr, .addr_in, .promisc, .rx_rd, .rx_head, .rx_evt, .irq_clr, .addr_q_o, .rx_accept,
    .rx_count, .tx_reject, .line_vld, .irq_raw, .irq_mask, .irq);
`default_nettype wire

// File: verif/epf_phy.sv
// Line-side receiver model: captures serial bits
`default_nettype none
module epf_phy (
    input wire logic ref_clk, // Clock
    input wire logic sys_rst, // Sync reset
    input wire logic line_bit, // Serial bit
    input wire logic line_vld, // Bit valid
    output logic [47:0] cap, // Last 48 bits, newest at top
    output logic [15:0] nbits // Bits seen
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cap <= 48'h0000_0000_0000;
            nbits <= 16'h0000;
        end else if (line_vld) begin
            cap <= {line_bit, cap[47:1]};
            nbits <= nbits + 16'h0001;
        end
    end
endmodule // epf_phy
`default_nettype wire

// File: verif/tb.sv
// Testbench for the host-side packet path
`default_nettype none
module tb
    import epf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DEP = 16; // Small TX depth
    logic ref_clk = 0, sys_rst = 1, addr_wr = 0, promisc = 0, addr_send = 0, tx_wr = 0;
    logic tx_go = 0, rx_rd = 0, rx_accept, tx_empty, tx_reject, line_bit, line_vld, irq;
    logic [47:0] addr_in = '0, rx_dst = '0, addr_q_o, cap;
    logic [15:0] tx_len = '0, nbits;
    logic [IRQ_W-1:0] irq_en = '0, irq_clr = '0, irq_raw, irq_mask;
    logic [5:0] rx_count;
    epf_byte_t tx_byte = '0, rx_head = '0;
    epf_rx_evt_t rx_evt = '0;
    int err_count = 0, tests_run = 0, cyc = 0;
    epf_top #(.TX_DEPTH(DEP)) i_dut (.ref_clk, .sys_rst, .addr_wr, .addr_in, .promisc,
        .addr_send, .tx_wr, .tx_byte, .tx_go, .tx_len, .rx_rd, .rx_head, .rx_evt, .rx_dst,
        .irq_en, .irq_clr, .addr_q_o, .rx_accept, .rx_count, .tx_empty, .tx_reject,
        .line_bit, .line_vld, .irq_raw, .irq_mask, .irq);
    epf_phy i_phy (.ref_clk, .sys_rst, .line_bit, .line_vld, .cap, .nbits);
    // Clock of 8 ns
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic step(int n = 1);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(string nm, logic [47:0] got, logic [47:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Waits for the line model to count n more bits
    task automatic wait_bits(int n);
        int t = nbits + n;
        for (int i = 0; i < 600 && nbits < t; i++) step();
        step(4);
        chk("bit count", nbits, t);
    endtask
    // Opens a TX load; the opening write is not stored
    task automatic tx_open;
        tx_wr = 1;
        tx_byte = '{8'h00, 1'b1, 1'b0};
        step();
    endtask
    task automatic t_addr;
        addr_in = 48'h1234_5678_9abc; addr_wr = 1; step(); addr_wr = 0;
        chk("address", addr_q_o, addr_in);
        addr_send = 1; step(); addr_send = 0;
        wait_bits(48);
        chk("address wire", cap, 48'hbc9a_7856_3412);
        promisc = 0; rx_dst = addr_in; step(2);
        chk("match accept", rx_accept, 1);
        rx_dst = 48'h0000_0000_0001; step(2);
        chk("mismatch drop", rx_accept, 0);
        rx_dst = 48'h0100_0000_0000;
        step(2);
        chk("multicast accept", rx_accept, 1);
        $display("test address done");
    endtask
    // Lengths that the FIFO must refuse
    logic [15:0] tx_len_set [2] = '{16'h0000, 16'(DEP + 1)};
    task automatic t_tx;
        tx_open();
        tx_byte = '{8'ha1, 1'b0, 1'b0}; step(); tx_byte = '{8'hb2, 1'b0, 1'b0}; step();
        tx_byte = '{8'hc3, 1'b0, 1'b1}; step(); tx_wr = 0;
        tx_len = 16'h0003; tx_go = 1; step(); tx_go = 0; step();
        chk("tx busy", tx_empty, 0);
        wait_bits(24);
        chk("tx wire", cap[47:24], 48'h0000_00c3_b2a1);
        chk("tx empty", tx_empty, 1);
        chk("tx done status", irq_raw[IRQ_TX], 1);
        foreach (tx_len_set[i]) begin
            tx_open(); tx_wr = 0;
            tx_len = tx_len_set[i]; tx_go = 1; step(); tx_go = 0;
            chk("tx reject", tx_reject, 1);
            wait_bits(0);
        end
        $display("test transmit done");
    endtask
    task automatic t_rx;
        promisc = 1; irq_clr = 4'hf; step(); irq_clr = '0; irq_en = 4'h5;
        rx_evt = '{1'b1, 1'b1, 1'b0}; step(2); rx_evt = '0; step();
        chk("count two", rx_count, 2);
        chk("rx pending", irq_raw[IRQ_RX], 1);
        chk("masked", irq_mask, 4'h1);
        chk("irq line", irq, 1);
        rx_rd = 1; rx_head = '{8'h55, 1'b1, 1'b0}; step(); rx_rd = 0; step();
        chk("partial read", rx_count, 2);
        for (int i = 0; i < 2; i++) begin
            rx_rd = 1; rx_head = '{8'h66, 1'b0, 1'b1}; step(); rx_rd = 0; step();
            chk("count after read", rx_count, 1 - i);
        end
        irq_clr = 4'h1; step(); irq_clr = '0; step();
        chk("cleared", irq, 0);
        rx_evt = '{1'b1, 1'b0, 1'b1}; step(); rx_evt = '0; step();
        chk("overflow", irq_raw[IRQ_RXOF], 1);
        chk("overflow irq", irq, 1);
        rx_evt = '{1'b1, 1'b0, 1'b0};
        step();
        rx_evt = '0;
        step();
        chk("rx error raw", irq_raw[IRQ_RXER], 1);
        chk("rx error masked", irq_mask[IRQ_RXER], 0);
        chk("rx error count", rx_count, 0);
        $display("test receive done");
    endtask
    // Reset release: FIFO free, status and count clear
    task automatic t_reset;
        step(2);
        sys_rst = 0;
        step();
        chk("reset empty", tx_empty, 1);
        chk("reset status", irq_raw, 0);
        chk("reset count", rx_count, 0);
        $display("test reset done");
    endtask
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            results();
        end
    end
    initial begin
        t_reset();
        t_addr();
        t_tx();
        t_rx();
        results();
    end
endmodule // tb
`default_nettype wire
